// file: mflm_top.sv
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
// Behaviour
// - a short to ground is seen through a high-side current sense per bridge.
// - a short is confirmed only after three further consecutive detections.
// - a confirmed short turns off only its bridge and sets its own flag.
// - each coil's open flag is set when its target current is not reached.
// - open flags are read back and raise interrupt status bits, but never act on the bridges.
// - open load is not evaluated while the motor stands still.
// - the signed threshold is neutral at 0, positive values desensitise.
// - with the filter bit set, one result is made per four fullsteps.
// - the load result is larger for less load and 0 for highest load.
// - the stall output is active only while step time is at or below limit.
module mflm_top
    import mflm_pkg::*;
#(
    parameter int LW = mflm_pkg::LOAD_W
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // bridge sense
    input wire logic [1:0] hs_check_strobe,
    input wire logic [1:0] hs_overcurrent,
    input wire logic [1:0] coil_current_reached,
    // motion and load sense
    input wire logic fullstep_strobe,
    input wire logic standstill,
    input wire logic [LW-1:0] load_raw,
    input wire logic [mflm_pkg::STEP_W-1:0] measured_step_time,
    // outputs
    output logic [1:0] bridge_enable,
    output logic stall_out,
    output logic irq
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic drv_en;
        logic filt_en;
        logic [THR_W-1:0] thr;
        logic [STEP_W-1:0] lvt;
        logic [IRQ_W-1:0] mask;
        logic [IRQ_W-1:0] irq_st;
        logic [1:0] short_d;
        logic [1:0] open_ld;
        logic [LW-1:0] load_res;
        logic [LW+1:0] acc;
        logic [1:0] grp;
        logic upd;
        logic stall;
    } mflm_state_t;

    localparam logic [LW+1:0] LOAD_MAX = {2'b00, {LW{1'b1}}};

    mflm_state_t s_r;
    mflm_state_t s_nxt;
    logic [1:0] short_flag;
    logic [1:0] bridge_on;

    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return r;
    endfunction : be_merge

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_bridge
            mflm_short_filter u_short (
                .clk(clk),
                .rst_n(rst_n),
                .driver_enable(s_r.drv_en),
                .check_strobe(hs_check_strobe[g]),
                .hs_overcurrent(hs_overcurrent[g]),
                .short_flag(short_flag[g]),
                .bridge_on(bridge_on[g])
            );
        end
    endgenerate

    // open flags do not enter this path
    assign bridge_enable = bridge_on;

    logic access;
    logic done;
    logic [31:0] ctrl_word;
    logic [31:0] status_word;

    assign access = avs_read || avs_write;
    assign done = access && s_r.ack;
    assign avs_waitrequest = access && !s_r.ack;

    always_comb
    begin
        ctrl_word = 32'h0;
        ctrl_word[CTRL_DRV_EN] = s_r.drv_en;
        ctrl_word[CTRL_FILT_EN] = s_r.filt_en;
        ctrl_word[CTRL_THR_LSB +: THR_W] = s_r.thr;
        status_word = 32'h0;
        status_word[ST_SHORT_A] = short_flag[0];
        status_word[ST_SHORT_B] = short_flag[1];
        status_word[ST_OPEN_A] = s_r.open_ld[0];
        status_word[ST_OPEN_B] = s_r.open_ld[1];
        status_word[ST_STALL] = s_r.stall;
        status_word[ST_BRIDGE_A] = bridge_on[0];
        status_word[ST_BRIDGE_B] = bridge_on[1];
    end

    logic signed [LW+1:0] adj;
    logic [LW+1:0] clamped;
    logic [LW+1:0] sum;
    logic [31:0] wr;
    logic [IRQ_W-1:0] events;

    always_comb
    begin
        adj = '0;
        clamped = '0;
        sum = '0;
        wr = 32'h0;
        events = '0;
        s_nxt = s_r;
        s_nxt.ack = access && !s_r.ack;
        s_nxt.upd = 1'b0;
        s_nxt.stall = 1'b0;
        s_nxt.short_d = short_flag;

        // read data prepared in the wait cycle
        if (avs_read && !s_r.ack)
        begin
            case (avs_address)
                OFF_CTRL: s_nxt.rdata = ctrl_word;
                OFF_STATUS: s_nxt.rdata = status_word;
                OFF_LOAD: s_nxt.rdata = {{(32-LW){1'b0}}, s_r.load_res};
                OFF_LVT: s_nxt.rdata = {{(32-STEP_W){1'b0}}, s_r.lvt};
                OFF_IRQ_STATUS: s_nxt.rdata = {{(32-IRQ_W){1'b0}}, s_r.irq_st};
                OFF_IRQ_MASK: s_nxt.rdata = {{(32-IRQ_W){1'b0}}, s_r.mask};
                default: s_nxt.rdata = 32'h0;
            endcase
        end

        if (avs_write && done)
        begin
            case (avs_address)
                OFF_CTRL:
                begin
                    wr = be_merge(ctrl_word, avs_writedata, avs_byteenable);
                    s_nxt.drv_en = wr[CTRL_DRV_EN];
                    s_nxt.filt_en = wr[CTRL_FILT_EN];
                    s_nxt.thr = wr[CTRL_THR_LSB +: THR_W];
                end
                OFF_LVT:
                begin
                    wr = be_merge({{(32-STEP_W){1'b0}}, s_r.lvt},
                        avs_writedata, avs_byteenable);
                    s_nxt.lvt = wr[STEP_W-1:0];
                end
                OFF_IRQ_MASK:
                begin
                    wr = be_merge({{(32-IRQ_W){1'b0}}, s_r.mask},
                        avs_writedata, avs_byteenable);
                    s_nxt.mask = wr[IRQ_W-1:0];
                end
                default:
                begin
                    wr = 32'h0;
                end
            endcase
        end

        // open load sampled per fullstep while moving
        if (fullstep_strobe && !standstill)
            s_nxt.open_ld = ~coil_current_reached;

        // signed threshold offsets the raw measurement
        adj = $signed({2'b00, load_raw})
            + ($signed({{2{s_r.thr[THR_W-1]}}, {(LW-THR_W+2-2){s_r.thr[THR_W-1]}},
            s_r.thr}) <<< THR_SHIFT);
        if (adj < 0)
            clamped = '0;
        else if ($unsigned(adj) > LOAD_MAX)
            clamped = LOAD_MAX;
        else
            clamped = $unsigned(adj);

        if (!s_r.filt_en)
        begin
            s_nxt.grp = 2'h0;
            s_nxt.acc = '0;
        end
        if (fullstep_strobe)
        begin
            if (s_r.filt_en)
            begin
                sum = s_r.acc + clamped;
                if (s_r.grp == FILTER_LAST)
                begin
                    s_nxt.load_res = sum[LW+FILTER_SHIFT-1:FILTER_SHIFT];
                    s_nxt.upd = 1'b1;
                    s_nxt.acc = '0;
                    s_nxt.grp = 2'h0;
                end
                else
                begin
                    s_nxt.acc = sum;
                    s_nxt.grp = s_r.grp + 2'h1;
                end
            end
            else
            begin
                s_nxt.load_res = clamped[LW-1:0];
                s_nxt.upd = 1'b1;
            end
        end

        // stall pulse only inside the velocity window
        if (s_r.upd && s_r.load_res == '0 && measured_step_time <= s_r.lvt)
            s_nxt.stall = 1'b1;

        events[ST_SHORT_A] = short_flag[0] && !s_r.short_d[0];
        events[ST_SHORT_B] = short_flag[1] && !s_r.short_d[1];
        events[ST_OPEN_A] = s_nxt.open_ld[0] && !s_r.open_ld[0];
        events[ST_OPEN_B] = s_nxt.open_ld[1] && !s_r.open_ld[1];
        events[ST_STALL] = s_nxt.stall;
        // set beats clear-on-read; only bits already returned are cleared
        if (avs_read && done && avs_address == OFF_IRQ_STATUS)
            s_nxt.irq_st = (s_r.irq_st & ~s_r.rdata[IRQ_W-1:0]) | events;
        else
            s_nxt.irq_st = s_r.irq_st | events;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
            s_r.drv_en <= RESET_DRV_EN;
            s_r.filt_en <= RESET_FILT_EN;
            s_r.thr <= RESET_THR;
            s_r.lvt <= RESET_LVT;
            s_r.mask <= RESET_MASK;
        end
        else
            s_r <= s_nxt;
    end

    assign avs_readdata = s_r.rdata;
    assign stall_out = s_r.stall;
    assign irq = |(s_r.irq_st & s_r.mask);

    sequence seq_moving_step;
        fullstep_strobe && !standstill;
    endsequence

    sequence seq_filtered_step(logic [1:0] k);
        fullstep_strobe && s_r.filt_en && s_r.grp == k;
    endsequence

    chk_open_set_moving: assert property (@(posedge clk) disable iff (!rst_n)
        seq_moving_step |=> s_r.open_ld == ~$past(coil_current_reached))
        else $error("open flag not following target current");
    chk_open_hold_still: assert property (@(posedge clk) disable iff (!rst_n)
        standstill ##0 !fullstep_strobe [*1] |=> $stable(s_r.open_ld))
        else $error("open flag changed at standstill");
    chk_open_no_action: assert property (@(posedge clk) disable iff (!rst_n)
        bridge_enable == ({2{s_r.drv_en}} & ~short_flag))
        else $error("bridge state depends on more than shorts");
    chk_neutral_thr: assert property (@(posedge clk) disable iff (!rst_n)
        fullstep_strobe && !s_r.filt_en && s_r.thr == 7'h00
        |=> s_r.load_res == $past(load_raw))
        else $error("zero threshold altered the load result");
    chk_pos_thr_less: assert property (@(posedge clk) disable iff (!rst_n)
        fullstep_strobe && !s_r.filt_en && !s_r.thr[THR_W-1]
        |=> s_r.load_res >= $past(load_raw))
        else $error("positive threshold lowered the load result");
    chk_filter_four: assert property (@(posedge clk) disable iff (!rst_n)
        seq_filtered_step(2'h0) ##1 !fullstep_strobe [*1]
        |-> !s_r.upd)
        else $error("filtered result after a single fullstep");
    chk_filter_last: assert property (@(posedge clk) disable iff (!rst_n)
        seq_filtered_step(2'h3) |=> s_r.upd && s_r.grp == 2'h0)
        else $error("filtered result missing after fourth fullstep");
    chk_plain_update: assert property (@(posedge clk) disable iff (!rst_n)
        fullstep_strobe && !s_r.filt_en |=> s_r.upd)
        else $error("unfiltered result did not update");
    chk_stall_window: assert property (@(posedge clk) disable iff (!rst_n)
        stall_out |-> $past(measured_step_time) <= $past(s_r.lvt)
        && $past(s_r.load_res) == '0)
        else $error("stall output outside velocity window");
    chk_short_hold: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(short_flag[0]) || $fell(short_flag[1])
        |-> $past(s_r.drv_en) && !$past(s_r.drv_en, 2))
        else $error("short flag cleared without re-enable");

    chk_open_inert: assert property (
        @(posedge clk) disable iff (!rst_n)
        $changed(s_r.open_ld) && $stable(s_r.drv_en) && $stable(short_flag)
        |-> $stable(bridge_enable))
        else $error("open flag change moved a bridge");

    chk_bridge_own: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_r.drv_en && short_flag == 2'b01 |-> bridge_enable == 2'b10)
        else $error("short on coil A switched off coil B");

    chk_result_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        !fullstep_strobe |=> $stable(s_r.load_res))
        else $error("load result changed without a fullstep");

    chk_neg_thr_more: assert property (
        @(posedge clk) disable iff (!rst_n)
        fullstep_strobe && !s_r.filt_en && s_r.thr[THR_W-1]
        |=> s_r.load_res <= $past(load_raw))
        else $error("negative threshold raised the load result");

    chk_stall_pulse: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_r.upd && s_r.load_res == '0 && measured_step_time <= s_r.lvt
        |=> stall_out)
        else $error("stall missed inside velocity window");

    chk_stall_flagged: assert property (
        @(posedge clk) disable iff (!rst_n)
        stall_out |-> s_r.irq_st[ST_STALL])
        else $error("stall pulse without status bit");

    // every access answers after exactly one wait cycle
    chk_wait_single: assert property (
        @(posedge clk) disable iff (!rst_n)
        avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait state");
endmodule : mflm_top

// file: mflm_pkg.sv
package mflm_pkg;
    // register byte offsets
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_STATUS = 5'h04;
    localparam logic [4:0] OFF_LOAD = 5'h08;
    localparam logic [4:0] OFF_LVT = 5'h0C;
    localparam logic [4:0] OFF_IRQ_STATUS = 5'h10;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h14;
    // ctrl fields
    localparam int CTRL_DRV_EN = 0;
    localparam int CTRL_FILT_EN = 1;
    localparam int CTRL_THR_LSB = 8;
    localparam int THR_W = 7;
    // status / irq fields
    localparam int ST_SHORT_A = 0;
    localparam int ST_SHORT_B = 1;
    localparam int ST_OPEN_A = 2;
    localparam int ST_OPEN_B = 3;
    localparam int ST_STALL = 4;
    localparam int ST_BRIDGE_A = 5;
    localparam int ST_BRIDGE_B = 6;
    localparam int IRQ_W = 5;
    // widths and counts
    localparam int STEP_W = 20;
    localparam int LOAD_W = 10;
    localparam int THR_SHIFT = 2;
    localparam logic [1:0] SHORT_RETRIES = 2'h3;
    localparam logic [1:0] FILTER_LAST = 2'h3;
    localparam int FILTER_SHIFT = 2;
    // reset values
    localparam logic RESET_DRV_EN = 1'b0;
    localparam logic RESET_FILT_EN = 1'b0;
    localparam logic [THR_W-1:0] RESET_THR = 7'h00;
    localparam logic [STEP_W-1:0] RESET_LVT = 20'h00000;
    localparam logic [IRQ_W-1:0] RESET_MASK = 5'h00;
endpackage : mflm_pkg

// file: mflm_short_filter.sv
`timescale 1ns/100ps
module mflm_short_filter
    import mflm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // driver control and sense
    input wire logic driver_enable,
    input wire logic check_strobe,
    input wire logic hs_overcurrent,
    // result
    output logic short_flag,
    output logic bridge_on
);
    typedef struct packed {
        logic [1:0] cnt;
        logic flag;
        logic en_d;
    } mflm_sf_state_t;

    mflm_sf_state_t s_r;
    mflm_sf_state_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.en_d = driver_enable;
        if (driver_enable && !s_r.en_d)
        begin
            // re-enable releases the bridge
            s_nxt.flag = 1'b0;
            s_nxt.cnt = 2'h0;
        end
        else if (check_strobe && driver_enable && !s_r.flag)
        begin
            if (hs_overcurrent)
            begin
                if (s_r.cnt == SHORT_RETRIES)
                    s_nxt.flag = 1'b1;
                else
                    s_nxt.cnt = s_r.cnt + 2'h1;
            end
            else
                s_nxt.cnt = 2'h0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign short_flag = s_r.flag;
    // only this bridge goes off, and stays off
    assign bridge_on = driver_enable && !s_r.flag;

    chk_short_needs_retries: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(short_flag) |-> $past(s_r.cnt) == 2'h3 && $past(hs_overcurrent))
        else $error("short confirmed without three retries");
    chk_short_single_hit: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.cnt == 2'h0 && !short_flag |=> !short_flag)
        else $error("short flag without detection sequence");
    chk_bridge_off_short: assert property (@(posedge clk) disable iff (!rst_n)
        short_flag |-> !bridge_on)
        else $error("bridge on while short flag set");
endmodule : mflm_short_filter

// file: mflm_sense_model.sv
`timescale 1ns/100ps
module mflm_sense_model
    import mflm_pkg::*;
(
    // clock
    input wire logic clk,
    // bridge sense
    output logic [1:0] hs_check_strobe,
    output logic [1:0] hs_overcurrent,
    // step and load
    output logic fullstep_strobe,
    output logic [mflm_pkg::LOAD_W-1:0] load_raw
);
    initial
    begin
        hs_check_strobe = 2'h0;
        hs_overcurrent = 2'h0;
        fullstep_strobe = 1'b0;
        load_raw = '0;
    end

    // one high-side check on the bridges in sel
    task automatic hs_check(input logic [1:0] sel, input logic oc);
        hs_check_strobe <= sel;
        hs_overcurrent <= oc ? sel : 2'h0;
        @(posedge clk);
        hs_check_strobe <= 2'h0;
        // sense not held after the check
        hs_overcurrent <= oc ? ~sel : sel;
        @(posedge clk);
    endtask : hs_check

    // one fullstep with its raw load value
    task automatic step(input logic [mflm_pkg::LOAD_W-1:0] ld);
        fullstep_strobe <= 1'b1;
        load_raw <= ld;
        @(posedge clk);
        fullstep_strobe <= 1'b0;
        load_raw <= ~ld;
        @(posedge clk);
    endtask : step
endmodule : mflm_sense_model

// file: tb.sv
`timescale 1ns/100ps
module tb;
    import mflm_pkg::*;
    logic clk;
    logic rst_n;
    logic [4:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] hs_check_strobe;
    logic [1:0] hs_overcurrent;
    logic [1:0] coil_current_reached;
    logic fullstep_strobe;
    logic standstill;
    logic [LOAD_W-1:0] load_raw;
    logic [STEP_W-1:0] measured_step_time;
    logic [1:0] bridge_enable;
    logic stall_out;
    logic irq;
    logic [31:0] rd;
    logic [3:0] lanes;
    int mismatches;
    int checks;

    mflm_top #(.LW(LOAD_W)) mflm_top_inst (
        .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .hs_check_strobe(hs_check_strobe), .hs_overcurrent(hs_overcurrent),
        .coil_current_reached(coil_current_reached),
        .fullstep_strobe(fullstep_strobe), .standstill(standstill),
        .load_raw(load_raw), .measured_step_time(measured_step_time),
        .bridge_enable(bridge_enable), .stall_out(stall_out), .irq(irq)
    );

    mflm_sense_model mflm_sense_model_inst (
        .clk(clk), .hs_check_strobe(hs_check_strobe),
        .hs_overcurrent(hs_overcurrent), .fullstep_strobe(fullstep_strobe),
        .load_raw(load_raw)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= lanes;
        avs_write <= wr;
        avs_read <= ~wr;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
        if (n >= 20)
        begin
            mismatches++;
            stop_test();
        end
    endtask : bus

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rd_chk

    task automatic t_reset();
        check(32'(bridge_enable), 32'h0);
        rd_chk(OFF_CTRL, 32'h0);
        rd_chk(OFF_STATUS, 32'h0);
        rd_chk(OFF_LOAD, 32'h0);
        rd_chk(OFF_LVT, 32'h0);
        rd_chk(OFF_IRQ_MASK, 32'h0);
        rd_chk(5'h18, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_short();
        logic [1:0] sel;
        logic [1:0] keep;
        for (int b = 1; b <= 2; b++)
        begin
            sel = b[1:0];
            keep = ~sel;
            bus(1'b1, OFF_CTRL, 32'h1);
            check(32'(bridge_enable), 32'h3);
            repeat (3) mflm_sense_model_inst.hs_check(sel, 1'b1);
            mflm_sense_model_inst.hs_check(sel, 1'b0);
            repeat (3) mflm_sense_model_inst.hs_check(sel, 1'b1);
            check(32'(bridge_enable), 32'h3);
            mflm_sense_model_inst.hs_check(sel, 1'b1);
            check(32'(bridge_enable), 32'(keep));
            rd_chk(OFF_STATUS, {25'h0, keep, 3'h0, sel});
            bus(1'b1, OFF_CTRL, 32'h0);
            rd_chk(OFF_STATUS, {30'h0, sel});
            bus(1'b1, OFF_CTRL, 32'h1);
            rd_chk(OFF_STATUS, 32'h60);
        end
        $display("test short done");
    endtask : t_short

    task automatic t_open();
        standstill <= 1'b0;
        coil_current_reached <= 2'h1;
        mflm_sense_model_inst.step(10'h100);
        rd_chk(OFF_STATUS, 32'h68);
        check(32'(bridge_enable), 32'h3);
        standstill <= 1'b1;
        coil_current_reached <= 2'h2;
        mflm_sense_model_inst.step(10'h100);
        rd_chk(OFF_STATUS, 32'h68);
        standstill <= 1'b0;
        coil_current_reached <= 2'h3;
        mflm_sense_model_inst.step(10'h100);
        rd_chk(OFF_STATUS, 32'h60);
        $display("test open done");
    endtask : t_open

    task automatic t_load();
        logic [6:0] thr [4] = '{7'h05, 7'h3F, 7'h40, 7'h00};
        logic [9:0] ld [4] = '{10'h00A, 10'h320, 10'h064, 10'h1F4};
        logic [31:0] ex [4] = '{32'h1E, 32'h3FF, 32'h0, 32'h1F4};
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, OFF_CTRL, {17'h0, thr[i], 8'h01});
            mflm_sense_model_inst.step(ld[i]);
            rd_chk(OFF_LOAD, ex[i]);
        end
        bus(1'b1, OFF_CTRL, 32'h3);
        for (int j = 1; j <= 3; j++)
        begin
            mflm_sense_model_inst.step(10'(j * 100));
        end
        rd_chk(OFF_LOAD, 32'h1F4);
        mflm_sense_model_inst.step(10'h190);
        rd_chk(OFF_LOAD, 32'hFA);
        bus(1'b1, OFF_CTRL, 32'h1);
        $display("test load done");
    endtask : t_load

    task automatic t_stall();
        int seen;
        bus(1'b0, OFF_IRQ_STATUS, 32'h0);
        lanes = 4'h1;
        bus(1'b1, OFF_LVT, 32'hFFFFFF64);
        lanes = 4'hF;
        rd_chk(OFF_LVT, 32'h64);
        for (int k = 0; k < 2; k++)
        begin
            seen = 0;
            measured_step_time <= 20'(100 + k);
            mflm_sense_model_inst.step('0);
            repeat (6)
            begin
                @(posedge clk);
                if (stall_out === 1'b1)
                begin
                    seen++;
                end
            end
            check(32'(seen), (k == 0) ? 32'h1 : 32'h0);
        end
        check(32'(irq), 32'h0);
        bus(1'b1, OFF_IRQ_MASK, 32'h10);
        check(32'(irq), 32'h1);
        rd_chk(OFF_IRQ_STATUS, 32'h10);
        check(32'(irq), 32'h0);
        $display("test stall done");
    endtask : t_stall

    initial
    begin
        rst_n = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        coil_current_reached = 2'h3;
        standstill = 1'b0;
        measured_step_time = 20'h00000;
        lanes = 4'hF;
        mismatches = 0;
        checks = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_short();
        t_open();
        t_load();
        t_stall();
        stop_test();
    end
endmodule : tb
